/* File: bench/cpu_bus_model.sv */
// Processor bus and interrupt acknowledge model facing the support block.
// Assumes bench requests change on rising edges of sys_clk.
`timescale 1ns/1ps
module cpu_bus_model
   import cpu_support_pkg::*;
(
   // Clock
   input  wire logic       sys_clk,
   // Bench requests
   input  wire logic       cyc_req,
   input  wire logic [7:0] cyc_len,
   input  wire logic       ack_req,
   input  wire logic [2:0] mask,
   // Block outputs
   input  wire level_t     ipl_level,
   input  wire logic       bus_error,
   input  wire logic       cpu_reset,
   // Processor pins
   output logic            as_active = 1'b0,
   output logic            halt_active = 1'b0,
   output logic            iack_cycle = 1'b0,
   output logic [2:0]      iack_level = 3'h0
);
   int cnt = 0;
   int errs = 0;
   int acks = 0;
   // Bus cycles; a second bus error in a row halts
   always @(posedge sys_clk) begin
      if (cpu_reset) begin
         as_active <= 1'b0;
         halt_active <= 1'b0;
         errs <= 0;
      end else if (!as_active) begin
         as_active <= cyc_req && !halt_active;
         cnt <= 1;
      end else if (bus_error) begin
         as_active <= 1'b0;
         errs <= errs + 1;
         halt_active <= (errs >= 1);
      end else begin
         cnt <= cnt + 1;
         if (cnt >= cyc_len) begin
            as_active <= 1'b0;
            errs <= 0;
         end
      end
   end
   // Acknowledge only above the mask; level line wanders when idle
   always @(posedge sys_clk) begin
      if (acks > 0) begin
         acks <= acks - 1;
         iack_cycle <= (acks > 1);
      end else if (ack_req && ipl_level > mask) begin
         acks <= 4;
         iack_cycle <= 1'b1;
         iack_level <= ipl_level;
      end else begin
         iack_level <= ~iack_level;
      end
   end
endmodule : cpu_bus_model

/* File: bench/cpu_irq_watchdog_support_tb.sv */
// Self-checking bench for the processor support block.
// Assumes the bus model and design sources are compiled first.
`timescale 1ns/1ps
module cpu_irq_watchdog_support_tb;
   import cpu_support_pkg::*;
   logic       sys_clk = 1'b0, sys_rst = 1'b1, ext_av = 1'b0, supply_ok = 1'b1;
   logic       reset_sw = 1'b0, cyc_req = 1'b0, ack_req = 1'b0;
   logic [8:0] src = 9'h000;
   logic [7:0] cyc_len = 8'h01;
   logic [2:0] mask = 3'h0, iack_lvl;
   logic       as_act, halt_act, iack, av, berr, crst, led;
   level_t     ipl;
   int         bad_count = 0, total_checks = 0, cycles = 0;
   // Clock, 5 ns period
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   cpu_irq_watchdog_support #(.TIMEOUT_CYCLES(20), .STRETCH_CYCLES(4)) DUT (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .abort_sw(src[0]), .host_serial_irq(src[1]),
      .term_serial_irq(src[2]), .aux_serial_irq(src[3]), .speech_irq(src[4]),
      .parallel_adapter_irq(src[5]), .parallel_timer_unit_port_irq(src[6]),
      .parallel_timer_unit_timer_irq(src[7]), .ext_irq(src[8]), .ext_autovector(ext_av),
      .iack_cycle(iack), .iack_level(iack_lvl), .as_active(as_act), .halt_active(halt_act),
      .supply_ok(supply_ok), .reset_sw(reset_sw), .ipl_level(ipl), .autovector(av),
      .bus_error(berr), .cpu_reset(crst), .halt_indicator_led(led));
   cpu_bus_model cpu (.sys_clk(sys_clk), .cyc_req(cyc_req), .cyc_len(cyc_len),
      .ack_req(ack_req), .mask(mask), .ipl_level(ipl), .bus_error(berr), .cpu_reset(crst),
      .as_active(as_act), .halt_active(halt_act), .iack_cycle(iack), .iack_level(iack_lvl));
   task automatic w(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : w
   // Compare a level; callers sample at the falling edge, once outputs settle
   task automatic check_lvl(input level_t got, input level_t exp);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_lvl
   // Compare a single flag the same way
   task automatic check_bit(input logic got, input logic exp);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_bit
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done
   // Hang guard
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         bad_count = bad_count + 1;
         test_done();
      end
   end
   // Wait at falling edges until the block lets reset go; ends on a falling edge
   task automatic wait_reset_low();
      @(negedge sys_clk);
      for (int i = 0; i < 40 && crst !== 1'b0; i++) @(negedge sys_clk);
   endtask : wait_reset_low
   // Each source alone, its level and acknowledge kind, then priority and mask
   task automatic test_levels();
      level_t lv [10] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h4, 3'h4, 3'h3, 3'h2, 3'h1, 3'h1};
      logic   ae [10] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
      @(posedge sys_clk);
      for (int i = 0; i < 10; i++) begin
         src <= 9'h001 << (i > 8 ? 8 : i);
         ext_av <= (i == 8);
         w(8);
         @(negedge sys_clk);
         check_lvl(ipl, lv[i]);
         @(posedge sys_clk);
         ack_req <= 1'b1;
         w(1);
         ack_req <= 1'b0;
         w(2);
         @(negedge sys_clk);
         check_bit(av, ae[i]);
         w(4);
      end
      src <= 9'h1ff;
      w(8);
      @(negedge sys_clk);
      check_lvl(ipl, 3'h7);
      @(posedge sys_clk);
      src <= 9'h1f8;
      mask <= 3'h7;
      ack_req <= 1'b1;
      w(8);
      @(negedge sys_clk);
      check_lvl(ipl, 3'h4);
      check_bit(iack, 1'b0);
      @(posedge sys_clk);
      ack_req <= 1'b0;
      mask <= 3'h0;
      src <= 9'h000;
      w(8);
      @(negedge sys_clk);
      check_lvl(ipl, 3'h0);
      $display("test levels done");
   endtask : test_levels
   // One bus cycle of len cycles; reports whether bus error came, ends on a rising edge
   task automatic bus(input logic [7:0] len, input logic exp);
      logic seen;
      @(posedge sys_clk);
      seen = 1'b0;
      cyc_req <= 1'b1;
      cyc_len <= len;
      w(2);
      cyc_req <= 1'b0;
      @(negedge sys_clk);
      for (int i = 0; i < 250 && as_act === 1'b1; i++) begin
         seen = seen | berr;
         @(negedge sys_clk);
      end
      check_bit(seen, exp);
      for (int i = 0; i < 20 && berr !== 1'b0; i++) @(negedge sys_clk);
      @(posedge sys_clk);
   endtask : bus
   task automatic test_watchdog();
      bus(8'd200, 1'b1);
      bus(8'd10, 1'b0);
      bus(8'd200, 1'b1);
      @(negedge sys_clk);
      check_bit(led, 1'b0);
      bus(8'd200, 1'b1);
      w(8);
      @(negedge sys_clk);
      check_bit(led, 1'b1);
      @(posedge sys_clk);
      reset_sw <= 1'b1;
      w(8);
      @(negedge sys_clk);
      check_bit(crst, 1'b1);
      @(posedge sys_clk);
      reset_sw <= 1'b0;
      wait_reset_low();
      check_bit(crst, 1'b0);
      check_bit(led, 1'b0);
      $display("test watchdog done");
   endtask : test_watchdog
   task automatic test_supply();
      @(posedge sys_clk);
      supply_ok <= 1'b0;
      w(30);
      @(negedge sys_clk);
      check_bit(crst, 1'b1);
      @(posedge sys_clk);
      supply_ok <= 1'b1;
      w(6);
      @(negedge sys_clk);
      check_bit(crst, 1'b1);
      wait_reset_low();
      check_bit(crst, 1'b0);
      $display("test supply done");
   endtask : test_supply
   initial begin
      w(5);
      @(negedge sys_clk);
      check_bit(crst, 1'b1);
      @(posedge sys_clk);
      sys_rst <= 1'b0;
      wait_reset_low();
      check_bit(crst, 1'b0);
      test_levels();
      test_watchdog();
      test_supply();
      test_done();
   end
endmodule : cpu_irq_watchdog_support_tb

/* File: src/cpu_irq_watchdog_support.sv */
// Processor support: interrupt level encoder, bus watchdog, halt lamp, reset.
// Assumes pin inputs other than iack_cycle and iack_level are asynchronous; all are active high after inversion.
// How it works
// - Requests are encoded onto seven levels, 7 highest, 0 meaning none pending.
// - Abort gives level 7, host serial level 6, terminal serial level 5, all autovectored.
// - Third serial, speech and parallel adapter share level 4, autovectored.
// - Timer unit port gives level 3 and its timer level 2, both device-vectored.
// - A bus cycle lasting over 10 us raises bus error.
// - While halt is driven the halt indicator lamp is lit.
// - Reset is held while the supply is below its threshold and for a stretch after it returns.
// - The front-panel reset switch also resets without cutting power.
`timescale 1ns/1ps
`include "cpu_support_defines.svh"
module cpu_irq_watchdog_support
   import cpu_support_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = `BUS_TIMEOUT_CYCLES,
   parameter int STRETCH_CYCLES = `RESET_STRETCH_CYC
) (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   // Interrupt sources, active high
   input  wire logic       abort_sw,
   input  wire logic       host_serial_irq,
   input  wire logic       term_serial_irq,
   input  wire logic       aux_serial_irq,
   input  wire logic       speech_irq,
   input  wire logic       parallel_adapter_irq,
   input  wire logic       parallel_timer_unit_port_irq,
   input  wire logic       parallel_timer_unit_timer_irq,
   input  wire logic       ext_irq,
   input  wire logic       ext_autovector,
   // Interrupt acknowledge
   input  wire logic       iack_cycle,
   input  wire logic [2:0] iack_level,
   // Processor bus
   input  wire logic       as_active,
   input  wire logic       halt_active,
   // Supply and panel
   input  wire logic       supply_ok,
   input  wire logic       reset_sw,
   // Outputs to processor
   output level_t          ipl_level,
   output logic            autovector,
   output logic            bus_error,
   output logic            cpu_reset,
   output logic            halt_indicator_led
);
   localparam int CW = $clog2(TIMEOUT_CYCLES + 2);
   localparam int SW = $clog2(STRETCH_CYCLES + 2);
   localparam int NIN = 14;
   logic [NIN-1:0] raw_in;
   logic [NIN-1:0] clean;
   pin_sync_if #(.W(NIN)) sif ();
   // Gather all pins except iack_cycle and iack_level for the synchroniser
   assign raw_in = {abort_sw, host_serial_irq, term_serial_irq, aux_serial_irq, speech_irq,
                    parallel_adapter_irq, parallel_timer_unit_port_irq,
                    parallel_timer_unit_timer_irq, ext_irq, ext_autovector,
                    as_active, halt_active, ~supply_ok, reset_sw};
   assign sif.raw = raw_in;
   assign clean   = sif.clean;
   pin_sync #(.W(NIN)) u_sync (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .p       (sif)
   );
   logic s_abort, s_host, s_term, s_aux, s_speech, s_pa, s_port, s_tmr, s_ext, s_extav;
   logic s_as, s_halt, s_low, s_rsw;
   assign {s_abort, s_host, s_term, s_aux, s_speech, s_pa, s_port, s_tmr,
           s_ext, s_extav, s_as, s_halt, s_low, s_rsw} = clean;
   // Priority encoder, highest level wins
   level_t next_level;
   always_comb begin
      next_level = `LVL_NONE;
      if (s_abort)                         next_level = `LVL_ABORT;
      else if (s_host)                     next_level = `LVL_HOST;
      else if (s_term)                     next_level = `LVL_TERM;
      else if (s_aux || s_speech || s_pa)  next_level = `LVL_SHARED;
      else if (s_port)                     next_level = `LVL_PORT;
      else if (s_tmr)                      next_level = `LVL_TIMER;
      else if (s_ext)                      next_level = `LVL_EXT;
   end
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) ipl_level <= `LVL_NONE;
      else         ipl_level <= next_level;
   end
   // Acknowledge type for the level being acknowledged
   logic next_av;
   always_comb begin
      case (iack_level)
         `LVL_PORT, `LVL_TIMER: next_av = 1'b0;
         `LVL_EXT:              next_av = s_extav;
         `LVL_NONE:             next_av = 1'b0;
         default:               next_av = 1'b1;
      endcase
   end
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) autovector <= 1'b0;
      else         autovector <= iack_cycle & next_av;
   end
   // Bus cycle watchdog; fault holds until the cycle ends
   bus_state_e  bstate;
   logic [CW-1:0] cnt;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bstate <= bus_idle;
         cnt    <= '0;
      end else begin
         case (bstate)
            bus_idle: begin
               cnt <= '0;
               if (s_as) bstate <= bus_timed;
            end
            bus_timed: begin
               if (!s_as) bstate <= bus_idle;
               else if (cnt >= CW'(TIMEOUT_CYCLES)) bstate <= bus_fault;
               else cnt <= cnt + 1'b1;
            end
            bus_fault: if (!s_as) bstate <= bus_idle;
            default: bstate <= bus_idle;
         endcase
      end
   end
   assign bus_error = (bstate == bus_fault);
   // Halt lamp follows the processor's halt output
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) halt_indicator_led <= 1'b0;
      else         halt_indicator_led <= s_halt;
   end
   // Reset generator, stretched after supply or switch release
   logic [SW-1:0] rcnt;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rcnt      <= '0;
         cpu_reset <= 1'b1;
      end else if (s_low || s_rsw) begin
         rcnt      <= '0;
         cpu_reset <= 1'b1;
      end else if (rcnt < SW'(STRETCH_CYCLES)) begin
         rcnt      <= rcnt + 1'b1;
         cpu_reset <= 1'b1;
      end else begin
         cpu_reset <= 1'b0;
      end
   end
   // Checks
   // Helper age of the current bus cycle, saturating at the age where bus error first shows
   localparam int AW = $clog2(TIMEOUT_CYCLES + 3);
   localparam logic [AW-1:0] AGE_MAX = AW'(TIMEOUT_CYCLES + 2);
   logic [AW-1:0] as_age;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst)                as_age <= '0;
      else if (!s_as)             as_age <= '0;
      else if (as_age != AGE_MAX) as_age <= as_age + 1'b1;
   end
   // No source above the port level is pending
   logic none_above_port;
   assign none_above_port = !(s_abort || s_host || s_term || s_aux || s_speech || s_pa);
   sequence cycle_long;
      s_as [*2];
   endsequence
   property abort_top_p;
      @(posedge sys_clk) disable iff (sys_rst) s_abort |=> ipl_level == 3'h7;
   endproperty
   abort_level_a: assert property (abort_top_p) else $error("abort not level 7");
   none_level_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (clean[NIN-1:4] == '0) |=> ipl_level == 3'h0) else $error("idle level");
   host_level_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!s_abort && s_host) |=> ipl_level == 3'h6) else $error("host level");
   term_level_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!s_abort && !s_host && s_term) |=> ipl_level == 3'h5) else $error("terminal level");
   shared_level_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!s_abort && !s_host && !s_term && s_speech) |=> ipl_level == 3'h4)
      else $error("shared level");
   port_level_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (none_above_port && s_port) |=> ipl_level == 3'h3) else $error("port level");
   timer_level_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (none_above_port && !s_port && s_tmr) |=> ipl_level == 3'h2)
      else $error("timer level");
   ext_level_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (none_above_port && !s_port && !s_tmr && s_ext) |=> ipl_level == 3'h1)
      else $error("external level");
   auto_type_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (iack_cycle && iack_level[2]) |=> autovector) else $error("upper level not autovectored");
   vector_type_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (iack_cycle && (iack_level == 3'h3 || iack_level == 3'h2)) |=> !autovector)
      else $error("vectored level autovectored");
   ext_type_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (iack_cycle && iack_level == 3'h1) |=> autovector == $past(s_extav))
      else $error("external ack type");
   berr_short_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !s_as |=> !bus_error) else $error("bus error after cycle end");
   berr_timeout_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (as_age == AGE_MAX) |-> bus_error) else $error("bus error late");
   berr_early_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (cycle_long ##0 (as_age < AGE_MAX)) |-> !bus_error) else $error("bus error early");
   halt_lamp_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_halt |=> halt_indicator_led) else $error("halt lamp dark");
   lamp_dark_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !s_halt |=> !halt_indicator_led) else $error("halt lamp lit without halt");
   reset_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (s_low || s_rsw) |=> cpu_reset [*2]) else $error("reset dropped");
endmodule : cpu_irq_watchdog_support

/* File: src/cpu_support_defines.svh */
// Timing counts and fixed level numbers for the processor support block.
// Assumes a 200 MHz system clock.
`ifndef CPU_SUPPORT_DEFINES_SVH
`define CPU_SUPPORT_DEFINES_SVH
`define CLK_PERIOD_PS       5000
`define BUS_TIMEOUT_NS      10000
`define BUS_TIMEOUT_CYCLES  ((`BUS_TIMEOUT_NS * 1000) / `CLK_PERIOD_PS)
`define RESET_STRETCH_CYC   16
`define LVL_ABORT           3'h7
`define LVL_HOST            3'h6
`define LVL_TERM            3'h5
`define LVL_SHARED          3'h4
`define LVL_PORT            3'h3
`define LVL_TIMER           3'h2
`define LVL_EXT             3'h1
`define LVL_NONE            3'h0
`endif

/* File: src/cpu_support_pkg.sv */
// Types shared by the processor support block.
// No assumptions beyond a SystemVerilog compiler.
package cpu_support_pkg;
   typedef logic [2:0] level_t;
   typedef enum logic [1:0] {
      bus_idle  = 2'b00,
      bus_timed = 2'b01,
      bus_fault = 2'b11
   } bus_state_e;
endpackage : cpu_support_pkg

/* File: src/pin_sync.sv */
// Three-stage synchroniser per bit; output moves when stages two and three agree.
// Assumes asynchronous inputs idle low at reset.
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   // Pins in, levels out
   pin_sync_if.sync  p
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic s1, s2, s3, q;
         // Shift chain and agreement filter
         always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
               s1 <= 1'b0;
               s2 <= 1'b0;
               s3 <= 1'b0;
               q  <= 1'b0;
            end else begin
               s1 <= p.raw[i];
               s2 <= s1;
               s3 <= s2;
               if (s2 == s3) q <= s3;
            end
         end
         assign p.clean[i] = q;
      end
   endgenerate
endmodule : pin_sync

/* File: src/pin_sync_if.sv */
// Interface carrying raw pins into the synchroniser and clean levels out.
// Assumes one system clock drives both ends.
`timescale 1ns/1ps
interface pin_sync_if #(parameter int W = 1);
   logic [W-1:0] raw;
   logic [W-1:0] clean;
   modport sync (input raw, output clean);
   modport user (output raw, input clean);
endinterface : pin_sync_if
